// File: hdl/fieldbus_word_pkg.sv
package fieldbus_word_pkg;

   // Status word bit positions
   localparam int ST_READY_ON = 0;
   localparam int ST_READY_RUN = 1;
   localparam int ST_RUNNING = 2;
   localparam int ST_FAULT = 3;
   localparam int ST_NO_COAST = 4;
   localparam int ST_NO_QUICK = 5;
   localparam int ST_INHIBIT = 6;
   localparam int ST_WARNING = 7;
   localparam int ST_AT_SPEED = 8;
   localparam int ST_REMOTE = 9;
   localparam int ST_ABOVE_LIMIT = 10;
   localparam int ST_ECHO = 15;

   // Command word bit positions in the bypass combination
   localparam int CW_START = 0;
   localparam int CW_DIR = 1;
   localparam int CW_FAULT_RESET = 2;
   localparam int CW_DIN_LSB = 3;
   localparam int CW_WATCHDOG = 11;

   // Reset values and unused status bit mask
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] COMMAND_RESET = 16'h0000;
   localparam logic [15:0] UNUSED_STATUS_MASK = 16'h7800;

   // Watchdog tick: delay is counted in milliseconds
   localparam int CLK_PERIOD_PS = 4000;
   localparam longint TICK_TIME_PS = 64'd1000000000;
   localparam int TICK_CYCLES = int'(TICK_TIME_PS / CLK_PERIOD_PS);

   // Absolute speed error within tolerance
   function automatic logic within_tolerance(input logic [15:0] a, input logic [15:0] b,
                                             input logic [15:0] tol);
      logic [15:0] diff;
      diff = (a > b) ? 16'(a - b) : 16'(b - a);
      return diff <= tol;
   endfunction

endpackage

// File: hdl/link_supervision_if.sv
`timescale 1ns/1ps
interface link_supervision_if;
   logic pulse;
   logic fault_reset;
   logic [15:0] delay_ms;
   logic timeout;

   modport supervisor (input pulse, input fault_reset, input delay_ms, output timeout);
   modport client (output pulse, output fault_reset, output delay_ms, input timeout);
endinterface

// File: hdl/link_watchdog_monitor.sv
`timescale 1ns/1ps
module link_watchdog_monitor
   import fieldbus_word_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
)
(
   input wire logic core_clk, // System clock
   input wire logic resetn, // Async reset, active low
   link_supervision_if.supervisor sup // Pulse in, timeout out
);

   localparam int TW = $clog2(TICK_LEN + 1);

   logic prev_pulse;
   logic [TW-1:0] tick_cnt;
   logic [15:0] ms_cnt;
   logic timeout;

   // Edge of the master pulse and millisecond tick
   wire pulse_edge = sup.pulse ^ prev_pulse;
   wire tick = (tick_cnt == TW'(TICK_LEN - 1));
   wire expired = (sup.delay_ms != 16'h0000) && (ms_cnt >= sup.delay_ms);
   wire [15:0] next_ms = pulse_edge ? 16'h0000 : (tick && ms_cnt != 16'hFFFF) ? 16'(ms_cnt + 16'h0001) : ms_cnt;

   assign sup.timeout = timeout;

   // Counters restart on every pulse edge; timeout set wins over reset request
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prev_pulse <= 1'b0;
         tick_cnt <= '0;
         ms_cnt <= 16'h0000;
         timeout <= 1'b0;
      end
      else
      begin
         prev_pulse <= sup.pulse;
         tick_cnt <= (tick || pulse_edge) ? '0 : TW'(tick_cnt + 1'b1);
         ms_cnt <= next_ms;
         timeout <= expired ? 1'b1 : (sup.fault_reset ? 1'b0 : timeout);
      end
   end

   // Supervision off when delay is zero
   AST_WD_DISABLED: assert property (@(posedge core_clk) disable iff (!resetn)
      (sup.delay_ms == 16'h0000 && !timeout) |=> !timeout)
      else $error("watchdog timed out with supervision disabled");

endmodule

// File: hdl/fieldbus_status_control_word.sv
`timescale 1ns/1ps
// Functional notes
// - Ready-on needs supply, init, contactor open, inhibit
// - Bit 1 follows ready to run
// - Running needs modulation, flux, brake open when brake feedback used
// - Bit 3 shows fault state
// - Bit 4 low while coast stop
// - Bit 5 low while quick stop
// - Inhibit set by stops, cleared by OFF
// - Warning bit follows warning, no acknowledge
// - Bit 8 when speed within tolerance
// - Bit 9 shows fieldbus control active
// - Bit 10 when speed above limit
// - Control bit 11 echoed to status 15
// - Start, direction, five digital inputs decoded
// - Watchdog pulse loss causes fault, zero disables
module fieldbus_status_control_word
   import fieldbus_word_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES // Cycles per watchdog millisecond
)
(
   input wire logic core_clk, // System clock, 250 MHz
   input wire logic resetn, // Async reset, active low
   input wire logic [15:0] command_data, // Control word from master
   input wire logic command_write, // Control word valid strobe
   input wire logic supply_on, // Power supply up
   input wire logic electronics_ready, // Electronics initialised
   input wire logic contactor_open, // Main contactor dropped out
   input wire logic pulses_inhibited, // Output pulses inhibited
   input wire logic ready_to_run, // Drive ready to run
   input wire logic modulating, // Drive running and modulating
   input wire logic flux_ready, // Rotor flux ready
   input wire logic brake_feedback_used, // Brake feedback in use
   input wire logic brake_open, // Brake opened
   input wire logic fault_state, // Drive fault state
   input wire logic coast_stop, // Coast stop command present
   input wire logic quick_stop, // Quick stop command present
   input wire logic off_command, // OFF command
   input wire logic warning, // Warning present
   input wire logic [15:0] speed_actual, // Actual speed
   input wire logic [15:0] speed_reference, // Speed reference
   input wire logic [15:0] speed_tolerance, // At-speed tolerance
   input wire logic [15:0] speed_limit, // Above-limit threshold
   input wire logic remote_control_active, // Fieldbus owns control
   input wire logic [15:0] watchdog_delay_ms, // Pulse loss delay, 0 = off
   output logic [15:0] drive_state_report_word, // Status word to master
   output logic start_request, // Start (1) or stop (0)
   output logic direction_ccw, // Counter-clockwise when high
   output logic fault_reset_pulse, // One cycle per rising edge
   output logic remote_digital_input_1, // Fieldbus digital input 1
   output logic remote_digital_input_2, // Fieldbus digital input 2
   output logic remote_digital_input_3, // Fieldbus digital input 3
   output logic remote_digital_input_4, // Fieldbus digital input 4
   output logic remote_digital_input_5, // Fieldbus digital input 5
   output logic link_watchdog_fault // Watchdog timeout fault
);

   link_supervision_if sup_if ();

   logic [15:0] bypass_command_word;
   logic prev_reset_bit;
   logic switch_on_inhibit;
   logic [15:0] status_word;
   logic reset_pulse;
   logic watchdog_fault;

   // Watchdog supervisor on control bit 11
   assign sup_if.pulse = bypass_command_word[CW_WATCHDOG];
   assign sup_if.fault_reset = reset_pulse;
   assign sup_if.delay_ms = watchdog_delay_ms;

   link_watchdog_monitor #(
      .TICK_LEN(TICK_LEN)
   ) u_watchdog (
      .core_clk(core_clk),
      .resetn(resetn),
      .sup(sup_if.supervisor)
   );

   // Status condition decode
   wire any_fault = fault_state || sup_if.timeout;
   wire cond_ready_on = supply_on && electronics_ready && contactor_open && pulses_inhibited;
   wire cond_running = modulating && flux_ready && (!brake_feedback_used || brake_open);
   wire at_speed = within_tolerance(speed_actual, speed_reference, speed_tolerance);
   wire above_limit = speed_actual > speed_limit;
   wire inhibit_set = any_fault || coast_stop || quick_stop;
   wire inhibit_clear = off_command && !coast_stop && !quick_stop;
   wire next_inhibit = inhibit_set ? 1'b1 : (inhibit_clear ? 1'b0 : switch_on_inhibit);
   wire reset_edge = bypass_command_word[CW_FAULT_RESET] && !prev_reset_bit;

   // Assemble the whole word at once
   logic [15:0] next_status;
   always_comb
   begin
      next_status = STATUS_RESET;
      next_status[ST_READY_ON] = cond_ready_on;
      next_status[ST_READY_RUN] = ready_to_run;
      next_status[ST_RUNNING] = cond_running;
      next_status[ST_FAULT] = any_fault;
      next_status[ST_NO_COAST] = !coast_stop;
      next_status[ST_NO_QUICK] = !quick_stop;
      next_status[ST_INHIBIT] = next_inhibit;
      next_status[ST_WARNING] = warning;
      next_status[ST_AT_SPEED] = at_speed;
      next_status[ST_REMOTE] = remote_control_active;
      next_status[ST_ABOVE_LIMIT] = above_limit;
      next_status[ST_ECHO] = bypass_command_word[CW_WATCHDOG];
   end

   // Command register written by master strobe
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         bypass_command_word <= COMMAND_RESET;
      else if (command_write)
         bypass_command_word <= command_data;
   end

   // Status, inhibit and fault reset edge registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         status_word <= STATUS_RESET;
         switch_on_inhibit <= 1'b0;
         prev_reset_bit <= 1'b0;
         reset_pulse <= 1'b0;
         watchdog_fault <= 1'b0;
      end
      else
      begin
         status_word <= next_status;
         switch_on_inhibit <= next_inhibit;
         prev_reset_bit <= bypass_command_word[CW_FAULT_RESET];
         reset_pulse <= reset_edge;
         watchdog_fault <= sup_if.timeout;
      end
   end

   // Outputs from registers
   assign drive_state_report_word = status_word;
   assign start_request = bypass_command_word[CW_START];
   assign direction_ccw = bypass_command_word[CW_DIR];
   assign remote_digital_input_1 = bypass_command_word[CW_DIN_LSB];
   assign remote_digital_input_2 = bypass_command_word[CW_DIN_LSB + 1];
   assign remote_digital_input_3 = bypass_command_word[CW_DIN_LSB + 2];
   assign remote_digital_input_4 = bypass_command_word[CW_DIN_LSB + 3];
   assign remote_digital_input_5 = bypass_command_word[CW_DIN_LSB + 4];
   assign fault_reset_pulse = reset_pulse;
   assign link_watchdog_fault = watchdog_fault;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // Inhibit release: stops removed then OFF
   sequence s_stops_removed;
      !coast_stop && !quick_stop && !any_fault;
   endsequence

   sequence s_off_given;
      off_command && !coast_stop && !quick_stop && !any_fault;
   endsequence

   // Level checks skip the first edge after reset, where the word still holds its reset value
   AST_READY_ON: assert property ($past(resetn)
      |-> drive_state_report_word[ST_READY_ON] == $past(cond_ready_on))
      else $error("ready to switch on bit wrong");

   AST_READY_RUN: assert property (ready_to_run |=> drive_state_report_word[ST_READY_RUN])
      else $error("ready to run bit not set");

   AST_RUNNING: assert property (modulating && flux_ready && brake_feedback_used && !brake_open
      |=> !drive_state_report_word[ST_RUNNING])
      else $error("running reported with brake closed");

   AST_FAULT: assert property ($past(resetn)
      |-> drive_state_report_word[ST_FAULT] == $past(fault_state || sup_if.timeout))
      else $error("fault bit wrong");

   AST_STOPS: assert property ($past(resetn)
      |-> drive_state_report_word[ST_NO_COAST] == !$past(coast_stop)
      && drive_state_report_word[ST_NO_QUICK] == !$past(quick_stop))
      else $error("stop bits wrong");

   AST_INHIBIT_SET: assert property (coast_stop |=> drive_state_report_word[ST_INHIBIT])
      else $error("inhibit not set after coast stop");

   AST_INHIBIT_CLEAR: assert property (s_stops_removed ##1 s_off_given |=> !drive_state_report_word[ST_INHIBIT])
      else $error("inhibit not cleared by OFF");

   AST_INHIBIT_HOLD: assert property (!off_command && !inhibit_set && switch_on_inhibit |=> switch_on_inhibit)
      else $error("inhibit cleared without OFF");

   AST_WARNING: assert property ($past(resetn)
      |-> drive_state_report_word[ST_WARNING] == $past(warning))
      else $error("warning bit wrong");

   AST_SPEED_FLAGS: assert property ($past(resetn)
      |-> drive_state_report_word[ST_ABOVE_LIMIT] == $past(speed_actual > speed_limit)
      && drive_state_report_word[ST_REMOTE] == $past(remote_control_active))
      else $error("speed limit or control flag wrong");

   AST_AT_SPEED: assert property (speed_actual == speed_reference |=> drive_state_report_word[ST_AT_SPEED])
      else $error("at speed bit not set on equal speed");

   AST_ECHO: assert property (command_write |=> ##1 drive_state_report_word[ST_ECHO] == $past(command_data[CW_WATCHDOG], 2))
      else $error("watchdog pulse not echoed");

   AST_RESET_EDGE: assert property (fault_reset_pulse |-> $past(bypass_command_word[CW_FAULT_RESET])
      && !$past(prev_reset_bit) ##1 !fault_reset_pulse)
      else $error("fault reset not a single edge pulse");

   AST_DECODE: assert property (command_write |=> start_request == $past(command_data[CW_START])
      && direction_ccw == $past(command_data[CW_DIR]) && remote_digital_input_5 == $past(command_data[7]))
      else $error("command decode wrong");

   AST_UNUSED_ZERO: assert property ((drive_state_report_word & UNUSED_STATUS_MASK) == 16'h0000)
      else $error("unused status bits not zero");

   AST_WD_FAULT: assert property (sup_if.timeout |=> drive_state_report_word[ST_FAULT] && link_watchdog_fault)
      else $error("watchdog timeout not reported as fault");

endmodule

// File: sim/plc_master_model.sv
`timescale 1ns/1ps
module plc_master_model (
   input wire logic core_clk, // System clock
   output logic [15:0] command_data, // Control word to the drive
   output logic command_write // One-cycle write strobe
);
   logic [15:0] last;
   // Idle data is scrambled so only strobed words count
   initial
   begin
      last = 16'h0000;
      command_data = 16'hFFFF;
      command_write = 1'b0;
   end
   // Whole word per strobe, launched after a falling edge
   task automatic send(input logic [15:0] w);
      @(negedge core_clk);
      last = w;
      command_data = w;
      command_write = 1'b1;
      @(negedge core_clk);
      command_write = 1'b0;
      command_data = ~w;
   endtask
   // Reset request as a low then high on bit 2
   task automatic fault_reset();
      send(last & 16'hFFFB);
      send(last | 16'h0004);
   endtask
   // Periodic pulse on bit 11, one toggle every three cycles
   task automatic wd_pulses(input int n);
      repeat (n)
      begin
         send(last ^ 16'h0800);
         @(negedge core_clk);
      end
   endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import fieldbus_word_pkg::*;
   typedef struct packed {logic [10:0] fl; logic [63:0] spd; logic [15:0] ex;} row_s;
   logic core_clk, resetn;
   logic supply_on, electronics_ready, contactor_open, pulses_inhibited, ready_to_run, modulating, flux_ready;
   logic brake_feedback_used, brake_open, warning, remote_control_active;
   logic fault_state, coast_stop, quick_stop, off_command;
   logic [15:0] speed_actual, speed_reference, speed_tolerance, speed_limit, watchdog_delay_ms;
   logic [15:0] command_data, drive_state_report_word, hits;
   logic command_write, start_request, direction_ccw, fault_reset_pulse, link_watchdog_fault;
   logic remote_digital_input_1, remote_digital_input_2, remote_digital_input_3;
   logic remote_digital_input_4, remote_digital_input_5;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   // Flags, speeds {actual, reference, tolerance, limit}, expected status
   row_s rows [6] = '{'{11'h000, 64'h0, 16'h0130},
      '{11'h780, 64'h0064_0069_0005_0064, 16'h0131},
      '{11'h700, 64'h0065_005F_0005_0064, 16'h0430},
      '{11'h078, 64'h0, 16'h0132}, '{11'h07F, 64'h0, 16'h03B6}, '{11'h030, 64'h0, 16'h0134}};
   // Stop steps {coast, quick, fault, off, expected status bits 6..3}
   logic [7:0] ih [10] = '{8'h8C, 8'h0E, 8'h16, 8'h4A, 8'h5A, 8'h0E, 8'h16, 8'h2F, 8'h0E, 8'h16};
   logic [15:0] cw [3] = '{16'h00A9, 16'hFF56, 16'h0000};

   plc_master_model i_master (.core_clk, .command_data, .command_write);

   fieldbus_status_control_word #(.TICK_LEN(4)) i_dut (.core_clk, .resetn, .command_data, .command_write,
      .supply_on, .electronics_ready, .contactor_open, .pulses_inhibited, .ready_to_run, .modulating,
      .flux_ready, .brake_feedback_used, .brake_open, .fault_state, .coast_stop, .quick_stop, .off_command,
      .warning, .speed_actual, .speed_reference, .speed_tolerance, .speed_limit, .remote_control_active,
      .watchdog_delay_ms, .drive_state_report_word, .start_request, .direction_ccw, .fault_reset_pulse,
      .remote_digital_input_1, .remote_digital_input_2, .remote_digital_input_3, .remote_digital_input_4,
      .remote_digital_input_5, .link_watchdog_fault);

   // 250 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         summarize();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic nx(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic set_flags(input logic [10:0] f);
      {supply_on, electronics_ready, contactor_open, pulses_inhibited, ready_to_run, modulating, flux_ready,
         brake_feedback_used, brake_open, warning, remote_control_active} = f;
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      resetn = 1'b0;
      set_flags(11'h000);
      {fault_state, coast_stop, quick_stop, off_command} = 4'h0;
      {speed_actual, speed_reference, speed_tolerance, speed_limit} = 64'h0;
      watchdog_delay_ms = 16'h0000;
      nx(20);
      check(drive_state_report_word, STATUS_RESET);
      resetn = 1'b1;
      nx(1);
      foreach (rows[i])
      begin
         set_flags(rows[i].fl);
         {speed_actual, speed_reference, speed_tolerance, speed_limit} = rows[i].spd;
         nx(1);
         check(drive_state_report_word, rows[i].ex);
      end
      $display("done: status table");
      foreach (ih[i])
      begin
         {coast_stop, quick_stop, fault_state, off_command} = ih[i][7:4];
         nx(1);
         check(16'(drive_state_report_word[6:3]), 16'(ih[i][3:0]));
      end
      off_command = 1'b0;
      $display("done: stops and inhibit");
      foreach (cw[i])
      begin
         i_master.send(cw[i]);
         nx(1);
         hits = 16'({remote_digital_input_5, remote_digital_input_4, remote_digital_input_3,
            remote_digital_input_2, remote_digital_input_1, direction_ccw, start_request});
         check(hits, 16'({cw[i][7:3], cw[i][1:0]}));
         nx(1);
         check(16'(drive_state_report_word[15]), 16'(cw[i][11]));
      end
      $display("done: command decode and echo");
      i_master.send(16'h0004);
      check(16'(fault_reset_pulse), 16'h0000);
      nx(1);
      check(16'(fault_reset_pulse), 16'h0001);
      nx(1);
      check(16'(fault_reset_pulse), 16'h0000);
      i_master.send(16'h0004);
      hits = 16'h0000;
      repeat (4)
      begin
         nx(1);
         hits = hits + 16'(fault_reset_pulse);
      end
      check(hits, 16'h0000);
      $display("done: fault reset edge");
      watchdog_delay_ms = 16'h0002;
      for (int k = 0; k < 40 && link_watchdog_fault !== 1'b1; k++)
         nx(1);
      nx(1);
      check(16'({link_watchdog_fault, drive_state_report_word[3]}), 16'h0003);
      watchdog_delay_ms = 16'h0000;
      i_master.fault_reset();
      nx(3);
      check(16'({link_watchdog_fault, drive_state_report_word[3]}), 16'h0000);
      i_master.wd_pulses(1);
      watchdog_delay_ms = 16'h0002;
      i_master.wd_pulses(10);
      check(16'(link_watchdog_fault), 16'h0000);
      watchdog_delay_ms = 16'h0000;
      $display("done: link watchdog");
      i_master.send(16'h0007);
      check(16'({start_request, direction_ccw}), 16'h0003);
      resetn = 1'b0;
      nx(1);
      check(drive_state_report_word, STATUS_RESET);
      check(16'({start_request, direction_ccw, link_watchdog_fault}), 16'h0000);
      resetn = 1'b1;
      nx(2);
      check(drive_state_report_word, 16'h0134);
      $display("done: mid-run reset");
      summarize();
   end
endmodule
